// [hw/pattern_lfsr.v]
// 511-state character pattern generator for the receive checker
// assumes advance is asserted once per character period
`timescale 1ns/1ps
`include "reclock_rx_selftest_regs.vh"
module pattern_lfsr #(
   parameter WIDTH = 10
) (
   input  wire             sys_clk,
   input  wire             rst_n,
   input  wire             reload,
   input  wire             advance,
   output wire [WIDTH-1:0] character,
   output wire             loopEnd
);
   reg  [8:0] state;
   wire [8:0] next_state;

   // x^9 + x^5 + 1, maximal length, 511 states
   assign next_state = {state[7:0], state[8] ^ state[4]};
   assign character  = {state[0], state};
   assign loopEnd    = (state == `LFSR_SEED);

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= `LFSR_SEED;
      end else if (reload) begin
         state <= `LFSR_SEED;
      end else if (advance) begin
         state <= next_state;
      end
   end
endmodule // pattern_lfsr

// [hw/reclock_rx_selftest_cfg.v]
// receive-side control: config banks, driver gating, pattern checker
// assumes all inputs synchronous to sys_clk, one character per clock
`timescale 1ns/1ps
`include "reclock_rx_selftest_regs.vh"
module reclock_rx_selftest_cfg #(
   parameter WORD_W        = 10,
   parameter SETTLE_CYCLES = `SETTLE_CYCLES
) (
   input  wire              sys_clk,
   input  wire              rst_n,
   input  wire              cfg_write_strobe_n,
   input  wire [2:0]        cfgAddr,
   input  wire [6:0]        cfgData,
   input  wire [WORD_W-1:0] rxChar,
   input  wire              rxPllLocked,
   output reg  [WORD_W-1:0] rxWord,
   output reg               selftest_status_bit,
   output reg               statusDriveEnable,
   output wire              reclock_out1_enable,
   output wire              reclock_out2_enable,
   output wire              tx_out1_enable,
   output wire              tx_out2_enable,
   output wire              reclockLogicPowered,
   output wire              rx_channel_power_on,
   output wire              reclockOutValid,
   output wire              selftestSelectInvalid,
   output wire [6:0]        staticSetting0,
   output wire [6:0]        staticSetting1,
   output wire [6:0]        txStatic5,
   output wire [6:0]        txStatic6
);
   localparam [4:0] ST_START = 5'h01;
   localparam [4:0] ST_WAIT  = 5'h02;
   localparam [4:0] ST_SYNC  = 5'h04;
   localparam [4:0] ST_RUN   = 5'h08;
   localparam [4:0] ST_LOOP  = 5'h10;

   localparam [2:0] CODE_IDLE  = 3'h0;
   localparam [2:0] CODE_MATCH = 3'h1;
   localparam [2:0] CODE_ERR   = 3'h3;
   localparam [2:0] CODE_LOOPA = 3'h2;
   localparam [2:0] CODE_LOOPB = 3'h4;
   localparam [2:0] CODE_WAIT  = 3'h5;

   localparam [5:0] ERR_LIMIT = `ERR_LIMIT;
   localparam [8:0] LOOP_LAST = `LOOP_CHARS - 1;
   localparam [19:0] SETTLE_LAST = SETTLE_CYCLES - 1;

   // banks; 3 and 4 kept so writes land somewhere defined
   reg [6:0] bank [0:7];
   integer   i;

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < 8; i = i + 1) begin
            bank[i] <= `RESET_BANK;
         end
         bank[`BANK_RECLOCK_DYN] <= `RESET_DYN;
      end else if (!cfg_write_strobe_n) begin
         bank[cfgAddr] <= cfgData;
      end
   end

   assign staticSetting0 = bank[`BANK_RECLOCK_S0];
   assign staticSetting1 = bank[`BANK_RECLOCK_S1];
   assign txStatic5      = bank[`BANK_TX_S5];
   assign txStatic6      = bank[`BANK_TX_S6];

   wire [6:0] dyn   = bank[`BANK_RECLOCK_DYN];
   wire [6:0] txDyn = bank[`BANK_TX_DYN];
   wire [1:0] rx_selftest_select = dyn[`DYN_SEL_HI:`DYN_SEL_LO];

   // driver enable bits reset low, so reset alone forces drivers off
   assign reclock_out1_enable = dyn[`DYN_OUT1_BIT];
   assign reclock_out2_enable = dyn[`DYN_OUT2_BIT];
   assign tx_out1_enable      = txDyn[`TXDYN_OUT1_BIT];
   assign tx_out2_enable      = txDyn[`TXDYN_OUT2_BIT];
   assign reclockLogicPowered = reclock_out1_enable | reclock_out2_enable;
   assign rx_channel_power_on = dyn[`DYN_RX_POWER_BIT];
   assign selftestSelectInvalid = (rx_selftest_select != `SEL_NORMAL) &&
                                  (rx_selftest_select != `SEL_CHECK);

   wire checkOn = (rx_selftest_select == `SEL_CHECK);

   // settle timer after leaving the fully-off state
   reg [19:0] settleCount;
   reg        settled;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         settleCount <= 20'h00000;
         settled     <= 1'b0;
      end else if (!reclockLogicPowered) begin
         settleCount <= 20'h00000;
         settled     <= 1'b0;
      end else if (!settled) begin
         if (settleCount == SETTLE_LAST) begin
            settled <= 1'b1;
         end
         settleCount <= settleCount + 20'h00001;
      end
   end
   assign reclockOutValid = settled;

   // checker
   reg  [4:0] state;
   reg  [4:0] next_state;
   reg  [5:0] balance;
   reg  [8:0] position;
   wire [WORD_W-1:0] expected;
   wire       atSeed;
   wire       match = (rxChar == expected);
   wire       lfsrReload = (next_state == ST_START) || (next_state == ST_WAIT);
   wire       lfsrAdvance = (next_state == ST_RUN) || (next_state == ST_LOOP) ||
                            (next_state == ST_SYNC);
   wire       overLimit = !match && (balance == ERR_LIMIT - 6'h01);

   pattern_lfsr #(
      .WIDTH     (WORD_W)
   ) u_lfsr (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .reload    (lfsrReload),
      .advance   (lfsrAdvance),
      .character (expected),
      .loopEnd   (atSeed)
   );

   always @* begin
      next_state = state;
      if (!checkOn || !rxPllLocked) begin
         next_state = ST_START;
      end else begin
         case (state)
            ST_START: next_state = ST_WAIT;
            ST_WAIT:  if (match) next_state = ST_SYNC;    // first pattern character
            ST_SYNC:  next_state = ST_RUN;
            ST_RUN, ST_LOOP: begin
               if (overLimit) begin
                  next_state = ST_WAIT;
               end else if (position == LOOP_LAST) begin
                  next_state = ST_LOOP;
               end else begin
                  next_state = ST_RUN;
               end
            end
            default:  next_state = ST_START;
         endcase
      end
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state    <= ST_START;
         balance  <= 6'h00;
         position <= 9'h000;
      end else begin
         state <= next_state;
         if (lfsrReload) begin
            balance  <= 6'h00;
            position <= 9'h000;
         end else if (state == ST_RUN || state == ST_LOOP) begin
            // balance tracks errors minus matches, floored at zero
            if (!match) begin
               balance <= balance + 6'h01;
            end else if (balance != 6'h00) begin
               balance <= balance - 6'h01;
            end
            position <= (position == LOOP_LAST) ? 9'h000 : position + 9'h001;
         end else if (state == ST_SYNC) begin
            position <= 9'h001;
         end
      end
   end

   // output register: status group {status, word[0], word[1]}
   reg [2:0] code;
   reg       loopToggle;
   always @* begin
      case (state)
         ST_START: code = CODE_IDLE;
         ST_WAIT:  code = CODE_WAIT;
         ST_SYNC:  code = CODE_MATCH;
         ST_RUN:   code = match ? CODE_MATCH : CODE_ERR;
         ST_LOOP:  code = loopToggle ? CODE_LOOPB : CODE_LOOPA;
         default:  code = CODE_IDLE;
      endcase
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rxWord              <= {WORD_W{1'b0}};
         selftest_status_bit <= 1'b0;
         statusDriveEnable   <= 1'b0;
         loopToggle          <= 1'b0;
      end else begin
         statusDriveEnable <= checkOn;
         if (state == ST_LOOP) begin
            loopToggle <= ~loopToggle;
         end
         if (checkOn) begin
            rxWord              <= {rxChar[WORD_W-1:2], code[0], code[1]};
            selftest_status_bit <= code[2];
         end else begin
            rxWord              <= rxChar;
            selftest_status_bit <= 1'b0;
         end
      end
   end
endmodule // reclock_rx_selftest_cfg

// [hw/reclock_rx_selftest_regs.vh]
// constants for the reclocker receive self-test and configuration block
// assumes includers are plain verilog modules clocked by sys_clk at 125 MHz
//
// Functional notes
// - each reclocker serial driver is switched on or off separately by configuration writes
// - disabled driver powers down; both off also powers down reclocker logic only
// - reset low turns every serial output driver off
// - after re-enabling the reclocker, outputs may be off-spec for 250 us
// - 10-bit parallel word; status bit driven only while self-test select is 10
// - enabled checker runs a 511-character LFSR matching the transmitter
// - synchronised checker compares each character, reports on two low bits and status
// - status group shows 010b or 100b one character per completed loop
// - errors exceeding matches by 16 abort, reset LFSR, wait for start
// - receive PLL loss of lock forces the checker to pattern start state
// - reset presets self-test latches so checking is off
// - reset returns every state machine, counter and latch to initial value
// - receive power latch 0 keeps receive PLL and analog disabled
// - eight write-only banks, seven bits wide, three-bit address
// - write strobe low loads data into the addressed bank
// - banks 0 to 2 hold reclocker receive channel A bits
// - 0,1,5,6 static; 2,7 dynamic; 3,4 reserved test banks
// - select 01 normal reception, 10 checking, 00 and 11 invalid
// - output enable latch 1 enables its driver, 0 disables it
`ifndef RECLOCK_RX_SELFTEST_REGS_VH
`define RECLOCK_RX_SELFTEST_REGS_VH

`define BANK_RECLOCK_S0    3'h0
`define BANK_RECLOCK_S1    3'h1
`define BANK_RECLOCK_DYN   3'h2
`define BANK_TEST3         3'h3
`define BANK_TEST4         3'h4
`define BANK_TX_S5         3'h5
`define BANK_TX_S6         3'h6
`define BANK_TX_DYN        3'h7

// dynamic bank field positions
`define DYN_RX_POWER_BIT   0
`define DYN_OUT1_BIT       1
`define DYN_OUT2_BIT       2
`define DYN_SEL_LO         3
`define DYN_SEL_HI         4
`define TXDYN_OUT1_BIT     0
`define TXDYN_OUT2_BIT     1

`define RESET_BANK         7'h00
`define RESET_DYN          7'h18
`define SEL_NORMAL         2'h1
`define SEL_CHECK          2'h2

`define CLK_PERIOD_NS      8
`define SETTLE_TIME_US     250
`define SETTLE_CYCLES      ((`SETTLE_TIME_US * 1000) / `CLK_PERIOD_NS)

`define LFSR_SEED          9'h1ff
`define LOOP_CHARS         511
`define ERR_LIMIT          16

`endif

// [sim/cfg_host.sv]
// host model driving the configuration latch port
// assumes the testbench calls write only after reset release
`timescale 1ns/1ps
module cfg_host (
   input  wire logic  sys_clk,
   output logic       strobeN,
   output logic [2:0] addr,
   output logic [6:0] data
);
   initial begin
      strobeN = 1'b1;
      addr    = 3'h7;
      data    = 7'h55;
   end
   // enables written after each reset constant bits are the caller's
   // boundary-scan reset lies outside this port
   task automatic write(input logic [2:0] a, input logic [6:0] d);
      @(posedge sys_clk);
      strobeN <= 1'b0;
      addr    <= a;
      data    <= d;
      @(posedge sys_clk);
      strobeN <= 1'b1;
      // released lines show the inverse, never the last value
      addr    <= ~a;
      data    <= ~d;
   endtask
endmodule // cfg_host

// [sim/reclock_rx_selftest_chk.sv]
// port checker for the receive self-test and configuration block
// assumes a bind from the testbench and one clock domain
`timescale 1ns/1ps
module reclock_rx_selftest_chk #(
   parameter WORD_W        = 10,
   parameter SETTLE_CYCLES = 20
) (
   input wire logic              sys_clk,
   input wire logic              rst_n,
   input wire logic              cfg_write_strobe_n,
   input wire logic [2:0]        cfgAddr,
   input wire logic [6:0]        cfgData,
   input wire logic              rxPllLocked,
   input wire logic [WORD_W-1:0] rxWord,
   input wire logic              selftest_status_bit,
   input wire logic              statusDriveEnable,
   input wire logic              reclock_out1_enable,
   input wire logic              reclock_out2_enable,
   input wire logic              reclockLogicPowered,
   input wire logic              rx_channel_power_on,
   input wire logic              reclockOutValid,
   input wire logic              selftestSelectInvalid
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire       wr2 = !cfg_write_strobe_n && cfgAddr == 3'h2;
   wire [2:0] grp = {selftest_status_bit, rxWord[0], rxWord[1]};
   logic [15:0] onCount;
   // saturates so a long powered spell never wraps back under the limit
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n || !reclockLogicPowered) onCount <= 16'h0000;
      else if (onCount != 16'hffff) onCount <= onCount + 16'h0001;
   end
   hold_banks_a: assert property (cfg_write_strobe_n |=> $stable({reclock_out1_enable,
      reclock_out2_enable, rx_channel_power_on, selftestSelectInvalid})) else $error("bank moved");
   out1_load_a: assert property (wr2 |=> reclock_out1_enable == $past(cfgData[1]))
      else $error("out1 latch wrong");
   out2_load_a: assert property (wr2 |=> reclock_out2_enable == $past(cfgData[2]))
      else $error("out2 latch wrong");
   rx_power_a: assert property (wr2 |=> rx_channel_power_on == $past(cfgData[0]))
      else $error("rx power latch wrong");
   logic_power_a: assert property (reclockLogicPowered ==
      (reclock_out1_enable | reclock_out2_enable)) else $error("reclock logic power wrong");
   sel_invalid_a: assert property (wr2 |=> selftestSelectInvalid ==
      ($past(cfgData[4]) == $past(cfgData[3]))) else $error("invalid select flag wrong");
   status_gate_a: assert property (!statusDriveEnable |-> !selftest_status_bit)
      else $error("status bit driven while off");
   settle_time_a: assert property (reclockOutValid |-> onCount >= SETTLE_CYCLES)
      else $error("outputs valid too early");
   reset_off_a: assert property ($rose(rst_n) |->
      !(reclock_out1_enable || reclock_out2_enable || statusDriveEnable)) else $error("not off");
   lock_loss_a: assert property (!rxPllLocked && statusDriveEnable ##1 statusDriveEnable
      |=> grp == 3'b000) else $error("no return to start on lock loss");
   cover property (wr2);
   cover property ($rose(reclockOutValid));
   cover property (!rxPllLocked && statusDriveEnable);
   cover property (statusDriveEnable && grp == 3'b010);
endmodule // reclock_rx_selftest_chk

// [sim/testbench.sv]
// self-checking bench for the receive self-test and configuration block
// assumes cfg_host as the configuration master
`timescale 1ns/1ps
module testbench;
   localparam int S = 20;
   logic sys_clk = 1'b0, rst_n = 1'b0, rxPllLocked = 1'b1;
   logic [9:0] rxChar = 10'h000;
   wire strobeN, stat, drvEn, o1, o2, t1, t2, pwr, rxPwr, valid, inval;
   wire [2:0] addr;
   wire [6:0] data, s0, s1, s5, s6;
   wire [9:0] rxWord;
   int n_mismatch = 0, cmp_count = 0;
   int nLoop = 0, nErr = 0;
   logic [8:0] txLfsr = 9'h1ff;
   always #4 sys_clk = ~sys_clk;
   cfg_host u_host (.sys_clk(sys_clk), .strobeN(strobeN), .addr(addr), .data(data));
   reclock_rx_selftest_cfg #(.WORD_W(10), .SETTLE_CYCLES(S)) u_dut (.sys_clk(sys_clk),
      .rst_n(rst_n), .cfg_write_strobe_n(strobeN), .cfgAddr(addr), .cfgData(data),
      .rxChar(rxChar), .rxPllLocked(rxPllLocked), .rxWord(rxWord), .selftest_status_bit(stat),
      .statusDriveEnable(drvEn), .reclock_out1_enable(o1), .reclock_out2_enable(o2),
      .tx_out1_enable(t1), .tx_out2_enable(t2), .reclockLogicPowered(pwr),
      .rx_channel_power_on(rxPwr), .reclockOutValid(valid), .selftestSelectInvalid(inval),
      .staticSetting0(s0), .staticSetting1(s1), .txStatic5(s5), .txStatic6(s6));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #20000;
      n_mismatch++;
      end_of_test();
   end
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(negedge sys_clk);
      chk("reset state", 6'b000001, {o1, o2, t1, t2, drvEn, inval});
      chk("rx power", 1'b0, rxPwr);
      $display("test reset done");
      u_host.write(3'h0, 7'h11);
      u_host.write(3'h1, 7'h22);
      u_host.write(3'h5, 7'h33);
      u_host.write(3'h6, 7'h44);
      u_host.write(3'h7, 7'h03);
      u_host.write(3'h3, 7'h7f);
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("banks", {7'h11, 7'h22, 7'h33, 7'h44, 2'b11}, {s0, s1, s5, s6, t1, t2});
      $display("test banks done");
      u_host.write(3'h2, 7'h13);
      @(negedge sys_clk);
      chk("out1 only", 4'hb, {o1, o2, pwr, rxPwr});
      // valid rises S edges after the enabling write lands
      repeat (S - 1) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("settle", 1'b0, valid);
      @(negedge sys_clk);
      chk("settled", 1'b1, valid);
      u_host.write(3'h2, 7'h14);
      @(negedge sys_clk);
      chk("out2 only", 5'h0d, {o1, o2, pwr, rxPwr, valid});
      u_host.write(3'h2, 7'h10);
      @(negedge sys_clk);
      @(negedge sys_clk);
      chk("both off", 2'b00, {pwr, valid});
      $display("test drivers done");
      for (int sel = 0; sel < 4; sel++) begin
         u_host.write(3'h2, {2'b00, sel[1:0], 3'b000});
         repeat (2) @(negedge sys_clk);
         chk("select", {sel == 2, sel == 0 || sel == 3, 1'b0}, {drvEn, inval, stat & ~drvEn});
      end
      u_host.write(3'h2, 7'h08);
      rxChar <= 10'h2a5;
      repeat (3) @(negedge sys_clk);
      chk("word", 10'h2a5, rxWord);
      $display("test select done");
      u_host.write(3'h2, 7'h10);
      rxChar <= 10'h000;
      rxPllLocked <= 1'b0;
      repeat (3) @(negedge sys_clk);
      chk("start state", 3'b000, {stat, rxWord[0], rxWord[1]});
      @(posedge sys_clk);
      rxPllLocked <= 1'b1;
      repeat (5) @(negedge sys_clk);
      chk("waiting status", 2'b11, {drvEn, stat});
      $display("test checker done");
      // far-end transmitter: 600 sequence characters, one full pass and part of the next, then a run of bad characters
      for (int k = 0; k < 640; k++) begin
         @(posedge sys_clk);
         rxChar <= (k < 600) ? {txLfsr[0], txLfsr} : 10'h000;
         txLfsr <= {txLfsr[7:0], txLfsr[8] ^ txLfsr[4]};
         @(negedge sys_clk);
         if ({stat, rxWord[0], rxWord[1]} == 3'b010) nLoop++;
         if ({stat, rxWord[0], rxWord[1]} == 3'b011) nErr++;
      end
      chk("loop marks", 1, nLoop);
      chk("error codes", 16, nErr);
      chk("abort to wait", 3'b101, {stat, rxWord[0], rxWord[1]});
      $display("test pattern done");
      u_host.write(3'h2, 7'h16);
      @(posedge sys_clk);
      rst_n <= 1'b0;
      @(negedge sys_clk);
      chk("mid reset", 5'b00001, {o1, o2, t1, t2, inval});
      @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (2) @(negedge sys_clk);
      chk("after reset", 4'b0000, {o1, o2, drvEn, valid});
      $display("test mid reset done");
      end_of_test();
   end
endmodule // testbench
bind reclock_rx_selftest_cfg reclock_rx_selftest_chk #(.WORD_W(WORD_W),
   .SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
   .cfg_write_strobe_n(cfg_write_strobe_n), .cfgAddr(cfgAddr), .cfgData(cfgData),
   .rxPllLocked(rxPllLocked), .rxWord(rxWord), .selftest_status_bit(selftest_status_bit),
   .statusDriveEnable(statusDriveEnable), .reclock_out1_enable(reclock_out1_enable),
   .reclock_out2_enable(reclock_out2_enable), .reclockLogicPowered(reclockLogicPowered),
   .rx_channel_power_on(rx_channel_power_on), .reclockOutValid(reclockOutValid),
   .selftestSelectInvalid(selftestSelectInvalid));
